// ==== shared/mttm_pkg.sv ====
// Constants and types shared by the motion task table manager.
// Functional notes
// - A home-required setting, only 0 or 1 and 1 after reset, decides whether homing must finish before any task may run.
// - With the home-required setting at 0 a task may run whether or not homing is complete.
// - With the home-required setting at 1 no task runs until homing is complete.
// - The list command returns every initialized table entry and no uninitialized one.
// - An entry counts as initialized only when its velocity, acceleration and deceleration are all nonzero.
// - Each entry holds position, velocity, control word, acceleration, deceleration, profile table number, next-task number and next-task delay.
// - The load command copies the entry chosen by the staging task number into all staging values.
// - List, load, start, next-task and task-number functions act only while operating mode 2 is selected.
// - The host gives exactly one argument, the task number, with start, and the device then runs that entry.
// - A requested task does not begin while the axis is not homed, subject to the home-required setting.
// - The staging next-task number spans 0 to 128, resets to 0, is stored by commit and replaced by load.
// - When an entry's control word selects chaining, the entry named by its next-task number starts after it completes.
// - A readable and writable staging task number, 0 to 128 and 0 after reset, picks the entry for commit and load.
// - Writing staging values never alters the table; only the commit command changes an entry.
// - The commit command writes all staging values into the entry chosen by the staging task number.
// - A commit with zero staging deceleration is rejected.
`default_nettype none
package mttm_pkg;
  localparam int unsigned TN_W    = 8;
  localparam int unsigned N_ENT   = 129;
  localparam logic [7:0]  TN_MAX  = 8'h80;
  localparam logic [3:0]  OPM_POS = 4'h2;
  localparam int unsigned CLK_NS  = 8;
  localparam int unsigned MS_NS   = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
  localparam int unsigned MS_CW   = 17;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_SNUM  = 8'h04;
  localparam logic [7:0] A_POS   = 8'h08;
  localparam logic [7:0] A_VEL   = 8'h0C;
  localparam logic [7:0] A_CNTL  = 8'h10;
  localparam logic [7:0] A_ACC   = 8'h14;
  localparam logic [7:0] A_DEC   = 8'h18;
  localparam logic [7:0] A_TNUM  = 8'h1C;
  localparam logic [7:0] A_MTNX  = 8'h20;
  localparam logic [7:0] A_TNXT  = 8'h24;
  localparam logic [7:0] A_CMD   = 8'h28;
  localparam logic [7:0] A_STAT  = 8'h2C;
  localparam logic [7:0] A_LNUM  = 8'h30;
  localparam logic [7:0] A_LPOS  = 8'h40;
  localparam logic [7:0] A_LVEL  = 8'h44;
  localparam logic [7:0] A_LCNTL = 8'h48;
  localparam logic [7:0] A_LACC  = 8'h4C;
  localparam logic [7:0] A_LDEC  = 8'h50;
  localparam logic [7:0] A_LTNUM = 8'h54;
  localparam logic [7:0] A_LMTNX = 8'h58;
  localparam logic [7:0] A_LTNXT = 8'h5C;
  // Field positions and reset values.
  localparam int unsigned CTRL_HREQ   = 0;
  localparam int unsigned CTRL_OPM    = 4;
  localparam logic        HREQ_RST    = 1'b1;
  localparam logic [3:0]  OPM_RST     = 4'h0;
  localparam int unsigned CMD_COMMIT  = 0;
  localparam int unsigned CMD_LOAD    = 1;
  localparam int unsigned CMD_LIST    = 2;
  localparam int unsigned CMD_START   = 3;
  localparam int unsigned CMD_ARG     = 8;
  localparam int unsigned ST_CERR     = 4;
  localparam int unsigned ST_SREF     = 5;
  localparam int unsigned CNTL_CHAIN  = 0;
  localparam logic [2:0]  TNUM_MAX    = 3'h7;

  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] vel;
    logic [15:0] cntl;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [2:0]  tnum;
    logic [7:0]  mtnext;
    logic [15:0] tnext;
  } mttm_rec_t;

  typedef enum logic [3:0] {
    S_CLR    = 4'h0,
    S_IDLE   = 4'h1,
    S_COMMIT = 4'h2,
    S_LD_RD  = 4'h3,
    S_LD_WB  = 4'h4,
    S_LS_RD  = 4'h5,
    S_LS_CHK = 4'h6,
    S_LS_HLD = 4'h7,
    S_ST_RD  = 4'h8,
    S_ST_CHK = 4'h9,
    S_RUN    = 4'hA,
    S_DLY    = 4'hB
  } mttm_state_t;

  // True when an entry holds a usable task.
  function automatic logic mttm_init(input mttm_rec_t r);
    return (r.vel != 32'h0) && (r.acc != 32'h0) && (r.dec != 32'h0);
  endfunction
endpackage
`default_nettype wire

// ==== core/mttm_mem.sv ====
// Single-port task table memory with registered read data.
`default_nettype none
module mttm_mem #(
  parameter int unsigned W  = 171,
  parameter int unsigned D  = 129,
  parameter int unsigned AW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  output logic [W-1:0]       rdata
);
  logic [W-1:0] mem [D];

  // Read data appears one edge after the address; a write reads old data.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ==== core/mttm_core.sv ====
// Motion task table manager: staging registers, task table and sequencer.
`default_nettype none
module mttm_core
  import mttm_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        homing_done,
  input  wire logic        task_done,
  output logic             task_go,
  output logic [7:0]       task_go_num,
  output mttm_rec_t        task_go_rec,
  output logic             task_active
);
  mttm_state_t      state_q;
  mttm_rec_t        stg_q;
  mttm_rec_t        lst_rec_q;
  mttm_rec_t        cur_q;
  mttm_rec_t        mem_rdata;
  mttm_rec_t        mem_wdata;
  logic [7:0]       stg_num_q;
  logic [7:0]       ptr_q;
  logic [7:0]       mem_addr;
  logic [7:0]       lst_num_q;
  logic [7:0]       act_num_q;
  logic [7:0]       wa;
  logic [7:0]       start_arg;
  logic [15:0]      dly_q;
  logic [MS_CW-1:0] ms_q;
  logic [3:0]       opm_q;
  logic [31:0]      rd_mux;
  logic [31:0]      prdata_q;
  logic             hreq_q;
  logic             lst_v_q;
  logic             lst_done_q;
  logic             cerr_q;
  logic             sref_q;
  logic             go_q;
  logic             hit;
  logic             wr_en;
  logic             mode2;
  logic             cmd_wr;
  logic             idle_ok;
  logic             c_commit;
  logic             c_load;
  logic             c_list;
  logic             c_start;
  logic             start_ok;
  logic             chain_ok;
  logic             lst_pop;
  logic             mem_we;
  logic             st_init;

  // Bus decode; the slave never stalls, so pready is always high.
  assign wa      = paddr[7:0];
  assign wr_en   = psel && penable && pwrite && hit;
  assign lst_pop = psel && penable && !pwrite && (wa == A_LNUM) && hit
                   && (state_q == S_LS_HLD);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;
  assign mode2   = (opm_q == OPM_POS);

  // Commands are taken one at a time, lowest bit first, only when idle.
  assign cmd_wr    = wr_en && (wa == A_CMD);
  assign idle_ok   = (state_q == S_IDLE) && mode2;
  assign start_arg = pwdata[CMD_ARG +: 8];
  assign c_commit  = cmd_wr && idle_ok && pwdata[CMD_COMMIT];
  assign c_load    = cmd_wr && idle_ok && pwdata[CMD_LOAD]
                     && !pwdata[CMD_COMMIT];
  assign c_list    = cmd_wr && idle_ok && pwdata[CMD_LIST]
                     && !pwdata[CMD_COMMIT] && !pwdata[CMD_LOAD];
  assign c_start   = cmd_wr && idle_ok && pwdata[CMD_START]
                     && !pwdata[CMD_COMMIT] && !pwdata[CMD_LOAD]
                     && !pwdata[CMD_LIST];
  // Home gate: a cleared setting lets tasks run unhomed.
  assign start_ok  = (start_arg <= TN_MAX)
                     && (!hreq_q || homing_done);
  assign chain_ok  = mode2 && (!hreq_q || homing_done);
  assign st_init   = mttm_init(mem_rdata);

  // Address map check and read data selection.
  always_comb begin
    hit    = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
    rd_mux = 32'h0;
    unique case (wa)
      A_CTRL:  rd_mux = {24'h0, opm_q, 3'h0, hreq_q};
      A_SNUM:  rd_mux = {24'h0, stg_num_q};
      A_POS:   rd_mux = stg_q.pos;
      A_VEL:   rd_mux = stg_q.vel;
      A_CNTL:  rd_mux = {16'h0, stg_q.cntl};
      A_ACC:   rd_mux = stg_q.acc;
      A_DEC:   rd_mux = stg_q.dec;
      A_TNUM:  rd_mux = {29'h0, stg_q.tnum};
      A_MTNX:  rd_mux = {24'h0, stg_q.mtnext};
      A_TNXT:  rd_mux = {16'h0, stg_q.tnext};
      A_CMD:   rd_mux = 32'h0;
      A_STAT:  rd_mux = {16'h0, act_num_q, 2'h0, sref_q, cerr_q,
                         lst_done_q, lst_v_q, task_active,
                         state_q != S_IDLE};
      A_LNUM:  rd_mux = {22'h0, lst_done_q, lst_v_q, lst_num_q};
      A_LPOS:  rd_mux = lst_rec_q.pos;
      A_LVEL:  rd_mux = lst_rec_q.vel;
      A_LCNTL: rd_mux = {16'h0, lst_rec_q.cntl};
      A_LACC:  rd_mux = lst_rec_q.acc;
      A_LDEC:  rd_mux = lst_rec_q.dec;
      A_LTNUM: rd_mux = {29'h0, lst_rec_q.tnum};
      A_LMTNX: rd_mux = {24'h0, lst_rec_q.mtnext};
      A_LTNXT: rd_mux = {16'h0, lst_rec_q.tnext};
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle, so it is stable all access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable) begin
      prdata_q <= hit ? rd_mux : 32'h0;
    end
  end

  // Control register; the setting is kept as bit 0 only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hreq_q <= HREQ_RST;
      opm_q  <= OPM_RST;
    end else if (wr_en && (wa == A_CTRL)) begin
      hreq_q <= pwdata[CTRL_HREQ];
      opm_q  <= pwdata[CTRL_OPM +: 4];
    end
  end

  // Staging values; out-of-range numbers are dropped, not clipped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_q     <= '0;
      stg_num_q <= 8'h00;
    end else if (state_q == S_LD_WB) begin
      stg_q <= mem_rdata;
    end else if (wr_en && mode2) begin
      unique case (wa)
        A_SNUM:  if (pwdata[31:0] <= 32'(TN_MAX)) begin
          stg_num_q <= pwdata[7:0];
        end
        A_POS:   stg_q.pos <= pwdata;
        A_VEL:   stg_q.vel <= pwdata;
        A_CNTL:  stg_q.cntl <= pwdata[15:0];
        A_ACC:   stg_q.acc <= pwdata;
        A_DEC:   stg_q.dec <= pwdata;
        A_TNUM:  if (pwdata[31:0] <= 32'(TNUM_MAX)) begin
          stg_q.tnum <= pwdata[2:0];
        end
        A_MTNX:  if (pwdata[31:0] <= 32'(TN_MAX)) begin
          stg_q.mtnext <= pwdata[7:0];
        end
        A_TNXT:  stg_q.tnext <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Table port: a write happens only on commit or the reset sweep.
  always_comb begin
    mem_we    = (state_q == S_COMMIT) || (state_q == S_CLR);
    mem_wdata = (state_q == S_COMMIT) ? stg_q : '0;
    mem_addr  = ((state_q == S_COMMIT) || (state_q == S_LD_RD))
                ? stg_num_q : ptr_q;
  end

  mttm_mem #(
    .W  ($bits(mttm_rec_t)),
    .D  (N_ENT),
    .AW (TN_W)
  ) u_mem (
    .clk   (pclk),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Sequencer. The table is cleared after reset so that no stale
  // entry can ever be listed; this costs 129 cycles of busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_CLR;
      ptr_q   <= 8'h00;
    end else begin
      unique case (state_q)
        S_CLR: begin
          ptr_q <= ptr_q + 8'h01;
          if (ptr_q == TN_MAX) begin
            state_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (c_commit) begin
            if (stg_q.dec != 32'h0) begin
              state_q <= S_COMMIT;
            end
          end else if (c_load) begin
            state_q <= S_LD_RD;
          end else if (c_list) begin
            ptr_q   <= 8'h00;
            state_q <= S_LS_RD;
          end else if (c_start && start_ok) begin
            ptr_q   <= start_arg;
            state_q <= S_ST_RD;
          end
        end
        S_COMMIT: state_q <= S_IDLE;
        S_LD_RD:  state_q <= S_LD_WB;
        S_LD_WB:  state_q <= S_IDLE;
        S_LS_RD:  state_q <= S_LS_CHK;
        S_LS_CHK: begin
          if (st_init) begin
            state_q <= S_LS_HLD;
          end else if (ptr_q == TN_MAX) begin
            state_q <= S_IDLE;
          end else begin
            ptr_q   <= ptr_q + 8'h01;
            state_q <= S_LS_RD;
          end
        end
        S_LS_HLD: begin
          if (lst_pop) begin
            if (ptr_q == TN_MAX) begin
              state_q <= S_IDLE;
            end else begin
              ptr_q   <= ptr_q + 8'h01;
              state_q <= S_LS_RD;
            end
          end
        end
        S_ST_RD:  state_q <= S_ST_CHK;
        S_ST_CHK: state_q <= st_init ? S_RUN : S_IDLE;
        S_RUN: begin
          if (task_done) begin
            if (cur_q.cntl[CNTL_CHAIN] && mode2) begin
              ptr_q   <= cur_q.mtnext;
              state_q <= S_DLY;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_DLY: begin
          if (dly_q == 16'h0) begin
            state_q <= chain_ok ? S_ST_RD : S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Listed record; a read of the number register pops it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lst_rec_q  <= '0;
      lst_num_q  <= 8'h00;
      lst_v_q    <= 1'b0;
      lst_done_q <= 1'b0;
    end else begin
      if (c_list) begin
        lst_v_q    <= 1'b0;
        lst_done_q <= 1'b0;
      end else if (state_q == S_LS_CHK) begin
        if (st_init) begin
          lst_rec_q <= mem_rdata;
          lst_num_q <= ptr_q;
          lst_v_q   <= 1'b1;
        end else if (ptr_q == TN_MAX) begin
          lst_done_q <= 1'b1;
        end
      end else if (lst_pop) begin
        lst_v_q    <= 1'b0;
        lst_done_q <= (ptr_q == TN_MAX);
      end
    end
  end

  // Sticky error flags; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cerr_q <= 1'b0;
      sref_q <= 1'b0;
    end else begin
      if (c_commit && (stg_q.dec == 32'h0)) begin
        cerr_q <= 1'b1;
      end else if (wr_en && (wa == A_STAT) && pwdata[ST_CERR]) begin
        cerr_q <= 1'b0;
      end
      if ((c_start && !start_ok)
          || ((state_q == S_ST_CHK) && !st_init)
          || ((state_q == S_DLY) && (dly_q == 16'h0) && !chain_ok)) begin
        sref_q <= 1'b1;
      end else if (wr_en && (wa == A_STAT) && pwdata[ST_SREF]) begin
        sref_q <= 1'b0;
      end
    end
  end

  // Task launch and the chain delay, counted in whole milliseconds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q      <= 1'b0;
      cur_q     <= '0;
      act_num_q <= 8'h00;
      dly_q     <= 16'h0;
      ms_q      <= '0;
    end else begin
      go_q <= (state_q == S_ST_CHK) && st_init;
      if ((state_q == S_ST_CHK) && st_init) begin
        cur_q     <= mem_rdata;
        act_num_q <= ptr_q;
      end
      if ((state_q == S_RUN) && task_done) begin
        dly_q <= cur_q.tnext;
        ms_q  <= '0;
      end else if ((state_q == S_DLY) && (dly_q != 16'h0)) begin
        if (ms_q == MS_CW'(CYC_MS - 1)) begin
          ms_q  <= '0;
          dly_q <= dly_q - 16'h1;
        end else begin
          ms_q <= ms_q + MS_CW'(1);
        end
      end
    end
  end

  assign task_go     = go_q;
  assign task_go_num = act_num_q;
  assign task_go_rec = cur_q;
  assign task_active = (state_q == S_RUN) || (state_q == S_DLY);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start_taken;
    c_start && start_ok;
  endsequence
  sequence s_go_arg;
    ##3 (task_go && (task_go_num == $past(start_arg, 3)))
      || sref_q;
  endsequence

  AST_HREQ_BLOCK: assert property (
    c_start && hreq_q && !homing_done |=> sref_q && state_q == S_IDLE)
    else $error("Start taken while homing was required and not done.");
  AST_HREQ_OFF: assert property (
    c_start && !hreq_q && start_arg <= TN_MAX |=> state_q == S_ST_RD)
    else $error("Start refused although homing was not required.");
  AST_START_SEQ: assert property (
    s_start_taken |-> s_go_arg)
    else $error("Started task is not the one named by the argument.");
  AST_GO_INIT: assert property (
    task_go |-> mttm_init(task_go_rec) && task_active)
    else $error("An uninitialized entry was launched.");
  AST_COMMIT_REJ: assert property (
    c_commit && stg_q.dec == 32'h0 |=> cerr_q && !mem_we)
    else $error("Commit with zero deceleration was not rejected.");
  AST_COMMIT_WR: assert property (
    c_commit && stg_q.dec != 32'h0
      |=> mem_we && mem_addr == stg_num_q && mem_wdata == stg_q)
    else $error("Commit did not write staging to the chosen entry.");
  AST_NO_STRAY_WR: assert property (
    mem_we && state_q != S_CLR |-> $past(c_commit))
    else $error("Table written without a commit command.");
  AST_LIST_INIT: assert property (
    $rose(lst_v_q) |-> mttm_init(lst_rec_q) && $past(ptr_q) == lst_num_q)
    else $error("Listed entry is not initialized.");
  AST_LIST_ORDER: assert property (
    lst_pop |=> ##[1:300] (lst_v_q || lst_done_q))
    else $error("List scan stalled after a pop.");
  AST_MODE_GATE: assert property (
    cmd_wr && !mode2 && state_q == S_IDLE |=> state_q == S_IDLE)
    else $error("Command acted on outside position mode.");
  AST_NUM_RANGE: assert property (
    stg_num_q <= TN_MAX && stg_q.mtnext <= TN_MAX)
    else $error("Staging number left its range.");
  AST_LOAD: assert property (
    state_q == S_LD_WB |=> stg_q == $past(mem_rdata))
    else $error("Load did not copy the entry into staging.");
  AST_CHAIN: assert property (
    state_q == S_RUN && task_done && cur_q.cntl[CNTL_CHAIN] && mode2
      |=> state_q == S_DLY && ptr_q == $past(cur_q.mtnext))
    else $error("Chained task not scheduled after completion.");
endmodule
`default_nettype wire

// ==== tb/mttm_axis_model.sv ====
// Axis model that answers each launched task with a completion pulse.
`default_nettype none
module mttm_axis_model #(
  parameter int unsigned RUN_CYC = 10
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic task_go,
  input  wire logic home_in,
  output logic      homing_done,
  output logic      task_done
);
  int unsigned cnt_q;
  // The homed flag lags the request by a cycle, like a real sensor.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) homing_done <= 1'b0;
    else homing_done <= home_in;
  end
  // A launch runs a fixed time; a short run keeps chains quick to test.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 0;
      task_done <= 1'b0;
    end else begin
      task_done <= (cnt_q == 1);
      if (task_go) cnt_q <= RUN_CYC;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_motion_task_table_manager.sv ====
// Self-checking bench for the motion task table manager.
`default_nettype none
module test_motion_task_table_manager import mttm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, home_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic        pready, pslverr, last_err, homing_done, task_done;
  logic        task_go, task_active;
  logic [7:0]  task_go_num, go_last;
  mttm_rec_t   task_go_rec;
  int          err_total = 0, tests_run = 0, go_cnt = 0, n;
  logic [7:0]  lq[$];
  logic [31:0] pq[$];
  logic [31:0] go_pos, st;

  always #4 pclk = ~pclk;

  mttm_core #(.CYC_MS(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .homing_done(homing_done), .task_done(task_done), .task_go(task_go),
    .task_go_num(task_go_num), .task_go_rec(task_go_rec),
    .task_active(task_active));
  mttm_axis_model u_axis (.pclk(pclk), .presetn(presetn),
    .task_go(task_go), .home_in(home_in), .homing_done(homing_done),
    .task_done(task_done));

  // Launches are counted at the falling edge, where the pulse has settled.
  always @(negedge pclk) begin
    if (task_go === 1'b1) begin
      go_cnt++;
      go_last = task_go_num;
      go_pos = task_go_rec.pos;
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task hang(input logic ok);
    if (!ok) begin
      err_total++;
      summarize();
    end
  endtask

  // One APB transfer; read data is taken at the edge that sees pready.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      ok = pready;
      rd_v = prdata;
      last_err = pslverr;
      k++;
    end while (ok !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    hang(ok === 1'b1);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task wait_idle;
    n = 0;
    do begin
      rd(A_STAT);
      n++;
    end while (rd_v[0] !== 1'b0 && n < 400);
    hang(rd_v[0] === 1'b0);
  endtask

  task wait_go(input int want);
    for (n = 0; n < 400 && go_cnt < want; n++) @(negedge pclk);
    hang(go_cnt >= want);
    for (n = 0; n < 400 && task_active !== 1'b0; n++) @(negedge pclk);
    hang(task_active === 1'b0);
  endtask

  // Acceleration copies velocity, so a zero velocity zeroes both.
  task commit(input logic [7:0] t, input logic [31:0] p, v,
              input logic [15:0] c, input logic [31:0] dd,
              input logic [7:0] nx, input logic [15:0] tx);
    wr(A_SNUM, {24'h0, t});
    wr(A_POS, p);
    wr(A_VEL, v);
    wr(A_CNTL, {16'h0, c});
    wr(A_ACC, v);
    wr(A_DEC, dd);
    wr(A_MTNX, {24'h0, nx});
    wr(A_TNXT, {16'h0, tx});
    wr(A_CMD, 32'h1);
    wait_idle();
  endtask

  task start(input logic [7:0] t);
    wr(A_CMD, {16'h0, t, 8'h08});
  endtask

  task t_reset;
    rd(A_CTRL);
    chk(rd_v, 32'h1);
    rd(A_SNUM);
    chk(rd_v, 32'h0);
    rd(A_MTNX);
    chk(rd_v, 32'h0);
    rd(8'h34);
    chk({31'h0, last_err}, 32'h1);
    wait_idle();
    wr(A_SNUM, 32'h5);
    rd(A_SNUM);
    chk(rd_v, 32'h0);
    wr(A_CTRL, 32'h21);
    wr(A_SNUM, 32'h81);
    rd(A_SNUM);
    chk(rd_v, 32'h0);
    wr(A_SNUM, 32'h80);
    rd(A_SNUM);
    chk(rd_v, 32'h80);
    wr(A_TNUM, 32'h8);
    rd(A_TNUM);
    chk(rd_v, 32'h0);
    wr(A_TNUM, 32'h7);
    rd(A_TNUM);
    chk(rd_v, 32'h7);
    $display("test reset and mode done");
  endtask

  task t_table;
    commit(8'h03, 32'h300, 32'hA, 16'h1, 32'h0, 8'h07, 16'h1);
    rd(A_STAT);
    chk({31'h0, rd_v[ST_CERR]}, 32'h1);
    wr(A_STAT, 32'h10);
    wr(A_CMD, 32'h2);
    wait_idle();
    rd(A_VEL);
    chk(rd_v, 32'h0);
    commit(8'h07, 32'h700, 32'h1, 16'h0, 32'h3, 8'h00, 16'h0);
    commit(8'h05, 32'h500, 32'h0, 16'h0, 32'h9, 8'h00, 16'h0);
    commit(8'h03, 32'h300, 32'hA, 16'h1, 32'hC, 8'h07, 16'h1);
    wr(A_POS, 32'h55);
    wr(A_MTNX, 32'h11);
    wr(A_SNUM, 32'h3);
    wr(A_CMD, 32'h2);
    wait_idle();
    rd(A_POS);
    chk(rd_v, 32'h300);
    rd(A_MTNX);
    chk(rd_v, 32'h7);
    rd(A_DEC);
    chk(rd_v, 32'hC);
    rd(A_TNXT);
    chk(rd_v, 32'h1);
    $display("test commit and load done");
  endtask

  // Status is polled so only real records are popped from the list.
  task t_list;
    wr(A_CMD, 32'h4);
    n = 0;
    do begin
      rd(A_STAT);
      st = rd_v;
      if (st[2] === 1'b1) begin
        rd(A_LPOS);
        pq.push_back(rd_v);
        rd(A_LNUM);
        lq.push_back(rd_v[7:0]);
      end
      n++;
    end while (st[3] !== 1'b1 && n < 600);
    hang(st[3] === 1'b1);
    chk(lq.size(), 32'h2);
    chk(pq[0], 32'h300);
    chk(pq[1], 32'h700);
    chk({24'h0, lq[0]}, 32'h3);
    chk({24'h0, lq[1]}, 32'h7);
    $display("test list done");
  endtask

  task t_start;
    start(8'h03);
    rd(A_STAT);
    chk({31'h0, rd_v[ST_SREF]}, 32'h1);
    chk(go_cnt, 32'h0);
    wr(A_STAT, 32'h20);
    wr(A_CTRL, 32'h20);
    start(8'h07);
    wait_go(1);
    chk({24'h0, go_last}, 32'h7);
    chk(go_pos, 32'h700);
    @(posedge pclk);
    home_in <= 1'b1;
    wr(A_CTRL, 32'h21);
    start(8'h03);
    wait_go(1 + 1);
    chk({24'h0, go_last}, 32'h3);
    wait_go(3);
    chk({24'h0, go_last}, 32'h7);
    wr(A_CTRL, 32'h01);
    start(8'h07);
    repeat (4) @(posedge pclk);
    rd(A_STAT);
    chk(go_cnt, 32'h3);
    $display("test start and chain done");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_table();
    t_list();
    t_start();
    summarize();
  end
endmodule
`default_nettype wire
